//--- verilog/ftc_pkg.sv
// Purpose: Shared constants and types for the four-channel trace capture unit.
// Assumes: One 20 MHz clock; status sources come from logic on that clock.
// Notes: Timebase tables are indexed by the time_per_division code in CTRL.

package ftc_pkg;

	// ----------------------------------------
	// Clock and sample timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SAMPLE_BASE_NS = 125000; // Smallest sample period, 125 us.
	localparam int BASE_CYCLES = (SAMPLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NCH = 4;
	localparam int NSRC = 8;
	localparam int ROLL_DEPTH = 2000;
	localparam int NRM_ENTRIES = 14;
	localparam int ROLL_ENTRIES = 9;
	localparam int ACC_SHIFT = 4; // Time constant of the AC coupling average.

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_CHSRC = 6'h04;
	localparam logic [5:0] REG_TRIG = 6'h08;
	localparam logic [5:0] REG_LEVEL = 6'h0c;
	localparam logic [5:0] REG_TMASK = 6'h10;
	localparam logic [5:0] REG_DMASK01 = 6'h14;
	localparam logic [5:0] REG_DMASK23 = 6'h18;
	localparam logic [5:0] REG_STATUS = 6'h1c;
	localparam logic [5:0] REG_RDADDR = 6'h20;
	localparam logic [5:0] REG_RDDATA = 6'h24;
	localparam logic [5:0] REG_RECINFO = 6'h28;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_MODE = 2;
	localparam int CTRL_TB = 4;
	localparam int CHSRC_DIG = 16;
	localparam int TRIG_RISING = 2;
	localparam int TRIG_COUPLE = 3;
	localparam int TRIG_PRE = 16;
	localparam int STAT_DONE = 2;
	localparam int STAT_REFUSED = 3;
	localparam int STAT_WRPTR = 16;
	localparam int RD_CH = 16;
	localparam int INFO_TOTAL = 16;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_DMASK = 16'hffff;
	localparam logic [15:0] RST_LEVEL = 16'h0000;
	localparam logic [15:0] RST_TMASK = 16'h0001;

	// ----------------------------------------
	// Timebase tables, periods in 125 us ticks
	// ----------------------------------------
	localparam logic [12:0] NRM_TICKS [NRM_ENTRIES] = '{
		13'd1, 13'd1, 13'd1, 13'd1, 13'd1, 13'd8, 13'd8,
		13'd16, 13'd20, 13'd80, 13'd100, 13'd200, 13'd500, 13'd1000};
	localparam logic [11:0] NRM_TOTAL [NRM_ENTRIES] = '{
		12'd40, 12'd80, 12'd160, 12'd400, 12'd800, 12'd200, 12'd500,
		12'd500, 12'd800, 12'd500, 12'd800, 12'd800, 12'd800, 12'd800};
	localparam logic [12:0] ROLL_TICKS [ROLL_ENTRIES] = '{
		13'd16, 13'd40, 13'd80, 13'd160, 13'd400, 13'd800, 13'd1600, 13'd4000, 13'd8000};

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {MODE_SINGLE, MODE_REPEAT, MODE_FREE, MODE_ROLL} ftc_mode_t;
	typedef enum logic [1:0] {CPL_DC, CPL_AC, CPL_DIG, CPL_RSV} ftc_couple_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_POST, ST_ROLL, ST_DONE} ftc_fsm_t;

	typedef struct packed {
		logic [NSRC-1:0][15:0] word;
	} ftc_status_t;

	typedef struct packed {
		logic waitreq;
		logic ack;
		logic [31:0] rdata;
		ftc_mode_t mode;
		logic [3:0] tb;
		logic [3:0] ch_en;
		logic [3:0][2:0] ch_sel;
		logic [3:0] ch_dig;
		logic [1:0] trig_ch;
		logic rising;
		ftc_couple_t couple;
		logic [11:0] pretrig;
		logic [15:0] level;
		logic [15:0] tmask;
		logic [3:0][15:0] dmask;
		logic [10:0] rd_idx;
		logic [1:0] rd_ch;
		ftc_fsm_t fsm;
		logic [15:0] tick_cnt;
		logic [12:0] per_cnt;
		logic [10:0] wr_ptr;
		logic [11:0] filled;
		logic [11:0] post_left;
		logic [10:0] start_ptr;
		logic prev_cond;
		logic have_prev;
		logic [15:0] avg;
		logic done;
		logic busy;
		logic refused;
		logic [7:0] rec_count;
	} ftc_state_t;

endpackage : ftc_pkg

//--- verilog/ftc_top.sv
// Purpose: Four-channel trace capture with triggered, free and rolling modes.
// Assumes: Avalon-MM slave with waitrequest; byte addresses; status_in on clk.
// Notes: Every register access takes exactly one wait cycle.

`timescale 1ns/10ps

module ftc_top import ftc_pkg::*; #(
	parameter int TICK_CYCLES = BASE_CYCLES,
	parameter int DEPTH = ROLL_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Avalon-MM register slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Internal status sources
	input wire ftc_status_t status_in,
	// Capture state
	output logic capture_busy,
	output logic record_ready
);

	// ----------------------------------------
	// State and sample memory
	// ----------------------------------------
	ftc_state_t s_q;
	ftc_state_t s_d;
	logic [63:0] mem [DEPTH];
	logic mem_we;
	logic [10:0] mem_wa;
	logic [63:0] mem_wd;

	// Byte-lane merge so partial writes leave other lanes untouched.
	function automatic logic [31:0] ftc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : ftc_merge

	// ----------------------------------------
	// Timebase lookup and channel assembly
	// ----------------------------------------
	logic [12:0] period_ticks;
	logic [11:0] total;
	logic [11:0] pre_eff;
	logic tick;
	logic sample_now;
	logic [3:0][15:0] ch_val;
	logic chans_ok;

	// Out-of-range codes clamp to the slowest entry rather than stall sampling.
	always_comb begin
		if (s_q.mode == MODE_ROLL) begin
			period_ticks = ROLL_TICKS[(s_q.tb < ROLL_ENTRIES) ? s_q.tb : 4'(ROLL_ENTRIES - 1)];
			total = 12'(DEPTH);
		end else begin
			period_ticks = NRM_TICKS[(s_q.tb < NRM_ENTRIES) ? s_q.tb : 4'(NRM_ENTRIES - 1)];
			total = NRM_TOTAL[(s_q.tb < NRM_ENTRIES) ? s_q.tb : 4'(NRM_ENTRIES - 1)];
		end
		pre_eff = (s_q.pretrig < total) ? s_q.pretrig : total - 12'd1;
		tick = (s_q.tick_cnt == 16'(TICK_CYCLES - 1));
		sample_now = tick && (s_q.per_cnt == period_ticks - 13'd1);
		chans_ok = s_q.ch_en[0] && (((s_q.ch_en + 4'd1) & s_q.ch_en) == 4'd0);
	end

	// Unassigned channels record zero so stale data never looks valid.
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			assign ch_val[c] = s_q.ch_en[c] ? status_in.word[s_q.ch_sel[c]] : 16'h0000;
		end
	endgenerate

	// ----------------------------------------
	// Trigger condition
	// ----------------------------------------
	logic [15:0] trig_val;
	logic [16:0] ac_diff;
	logic [15:0] avg_next;
	logic cond;
	logic trig_hit;

	always_comb begin
		trig_val = ch_val[s_q.trig_ch];
		ac_diff = {trig_val[15], trig_val} - {s_q.avg[15], s_q.avg};
		avg_next = s_q.avg + 16'($signed(ac_diff) >>> ACC_SHIFT);
		unique case (s_q.couple)
			CPL_DIG: cond = (s_q.tmask != 16'h0000) && ((trig_val & s_q.tmask) == s_q.tmask);
			CPL_AC: cond = $signed(trig_val - s_q.avg) >= $signed(s_q.level);
			default: cond = $signed(trig_val) >= $signed(s_q.level);
		endcase
		// Edge is judged between consecutive samples only.
		trig_hit = s_q.have_prev && (s_q.rising ? (cond && !s_q.prev_cond)
			: (!cond && s_q.prev_cond));
	end

	// ----------------------------------------
	// Register read view
	// ----------------------------------------
	logic [31:0] ctrl_rd;
	logic [31:0] chsrc_rd;
	logic [31:0] trig_rd;
	logic [31:0] rd_val;
	logic [15:0] mem_word;

	always_comb begin
		ctrl_rd = {24'h000000, s_q.tb, s_q.mode, 2'b00};
		chsrc_rd = '0;
		for (int c = 0; c < NCH; c++) begin
			chsrc_rd[4*c +: 4] = {s_q.ch_en[c], s_q.ch_sel[c]};
		end
		chsrc_rd[CHSRC_DIG +: 4] = s_q.ch_dig;
		trig_rd = {4'h0, s_q.pretrig, 11'h000, s_q.couple, s_q.rising, s_q.trig_ch};
		mem_word = mem[(s_q.rd_idx < 11'(DEPTH)) ? s_q.rd_idx : 11'd0][16*s_q.rd_ch +: 16];
		if (s_q.ch_dig[s_q.rd_ch]) begin
			mem_word = mem_word & s_q.dmask[s_q.rd_ch];
		end
		unique case (avs_address)
			REG_CTRL: rd_val = ctrl_rd;
			REG_CHSRC: rd_val = chsrc_rd;
			REG_TRIG: rd_val = trig_rd;
			REG_LEVEL: rd_val = {16'h0000, s_q.level};
			REG_TMASK: rd_val = {16'h0000, s_q.tmask};
			REG_DMASK01: rd_val = {s_q.dmask[1], s_q.dmask[0]};
			REG_DMASK23: rd_val = {s_q.dmask[3], s_q.dmask[2]};
			REG_STATUS: rd_val = {5'h00, s_q.wr_ptr, s_q.rec_count, 4'h0, s_q.refused, s_q.done,
				2'(s_q.fsm == ST_IDLE ? 2'd0 : (s_q.fsm == ST_DONE ? 2'd2 : 2'd1))};
			REG_RDADDR: rd_val = {14'h0000, s_q.rd_ch, 5'h00, s_q.rd_idx};
			REG_RDDATA: rd_val = {16'h0000, mem_word};
			REG_RECINFO: rd_val = {4'h0, total, 5'h00, s_q.start_ptr};
			default: rd_val = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	logic [31:0] w;
	logic start_req;
	logic restart;
	logic finish;
	logic [11:0] nxt_ptr;

	always_comb begin
		s_d = s_q;
		w = 32'h00000000;
		start_req = 1'b0;
		restart = 1'b0;
		finish = 1'b0;
		nxt_ptr = 12'(s_q.wr_ptr) + 12'd1;
		mem_we = 1'b0;
		mem_wa = s_q.wr_ptr;
		mem_wd = {ch_val[3], ch_val[2], ch_val[1], ch_val[0]};

		// Bus: the first cycle latches read data, the second drops waitrequest.
		s_d.ack = 1'b0;
		s_d.waitreq = 1'b1;
		if ((avs_read || avs_write) && !s_q.ack) begin
			s_d.ack = 1'b1;
			s_d.waitreq = 1'b0;
			if (avs_read) begin
				s_d.rdata = rd_val;
			end
		end

		// Register writes take effect on the edge that completes the transfer.
		if (avs_write && s_q.ack) begin
			unique case (avs_address)
				REG_CTRL: begin
					w = ftc_merge(ctrl_rd, avs_writedata, avs_byteenable);
					if ((w[CTRL_TB +: 4] != s_q.tb) || (w[CTRL_MODE +: 2] != s_q.mode)) begin
						restart = !w[CTRL_STOP] && (s_q.fsm inside {ST_ARMED, ST_POST, ST_ROLL});
					end
					s_d.tb = w[CTRL_TB +: 4];
					s_d.mode = ftc_mode_t'(w[CTRL_MODE +: 2]);
					start_req = w[CTRL_START];
					if (w[CTRL_STOP]) begin
						s_d.fsm = ST_IDLE;
					end
				end
				REG_CHSRC: begin
					w = ftc_merge(chsrc_rd, avs_writedata, avs_byteenable);
					for (int c = 0; c < NCH; c++) begin
						s_d.ch_en[c] = w[4*c + 3];
						s_d.ch_sel[c] = w[4*c +: 3];
					end
					s_d.ch_dig = w[CHSRC_DIG +: 4];
				end
				REG_TRIG: begin
					// Pretrigger and coupling apply from the next sample, no restart.
					w = ftc_merge(trig_rd, avs_writedata, avs_byteenable);
					s_d.trig_ch = w[1:0];
					s_d.rising = w[TRIG_RISING];
					s_d.couple = ftc_couple_t'(w[TRIG_COUPLE +: 2]);
					s_d.pretrig = w[TRIG_PRE +: 12];
				end
				REG_LEVEL: s_d.level = 16'(ftc_merge({16'h0000, s_q.level}, avs_writedata,
					avs_byteenable));
				REG_TMASK: s_d.tmask = 16'(ftc_merge({16'h0000, s_q.tmask}, avs_writedata,
					avs_byteenable));
				REG_DMASK01: {s_d.dmask[1], s_d.dmask[0]} = ftc_merge({s_q.dmask[1], s_q.dmask[0]},
					avs_writedata, avs_byteenable);
				REG_DMASK23: {s_d.dmask[3], s_d.dmask[2]} = ftc_merge({s_q.dmask[3], s_q.dmask[2]},
					avs_writedata, avs_byteenable);
				REG_STATUS: begin
					if (avs_byteenable[0] && avs_writedata[STAT_DONE]) begin
						s_d.done = 1'b0;
					end
					if (avs_byteenable[0] && avs_writedata[STAT_REFUSED]) begin
						s_d.refused = 1'b0;
					end
				end
				REG_RDADDR: begin
					w = ftc_merge({14'h0000, s_q.rd_ch, 5'h00, s_q.rd_idx}, avs_writedata,
						avs_byteenable);
					s_d.rd_idx = w[10:0];
					s_d.rd_ch = w[RD_CH +: 2];
				end
				default: begin
				end
			endcase
		end

		// Base tick and per-sample divider.
		s_d.tick_cnt = tick ? 16'h0000 : s_q.tick_cnt + 16'h0001;
		if (tick) begin
			s_d.per_cnt = sample_now ? 13'h0000 : s_q.per_cnt + 13'h0001;
		end

		// Sampling and capture sequencing.
		if (sample_now && (s_q.fsm inside {ST_ARMED, ST_POST, ST_ROLL})) begin
			mem_we = 1'b1;
			s_d.wr_ptr = (nxt_ptr >= total) ? 11'h000 : nxt_ptr[10:0];
			s_d.filled = (s_q.filled < total) ? s_q.filled + 12'd1 : total;
			s_d.prev_cond = cond;
			s_d.have_prev = 1'b1;
			s_d.avg = s_q.have_prev ? avg_next : trig_val;
			unique case (s_q.fsm)
				ST_ARMED: begin
					if (trig_hit && (s_q.filled >= pre_eff)) begin
						// Record begins pretrigger samples before the trigger sample.
						s_d.start_ptr = (12'(s_q.wr_ptr) >= pre_eff)
							? 11'(12'(s_q.wr_ptr) - pre_eff)
							: 11'(12'(s_q.wr_ptr) + total - pre_eff);
						s_d.post_left = total - pre_eff - 12'd1;
						if (total - pre_eff == 12'd1) begin
							finish = 1'b1;
						end else begin
							s_d.fsm = ST_POST;
						end
					end
				end
				ST_POST: begin
					s_d.post_left = s_q.post_left - 12'd1;
					finish = (s_q.post_left == 12'd1);
				end
				default: begin
				end
			endcase
		end

		// A full record is published, then the mode decides what follows.
		if (finish) begin
			s_d.done = 1'b1;
			s_d.rec_count = s_q.rec_count + 8'h01;
			if (s_q.mode == MODE_SINGLE) begin
				s_d.fsm = ST_DONE;
			end else begin
				restart = 1'b1;
			end
		end

		// Start request is refused when channel sources have a gap.
		if (start_req) begin
			if (chans_ok) begin
				restart = 1'b1;
				s_d.done = finish; // Completion in this very cycle is kept.
			end else begin
				s_d.refused = 1'b1;
			end
		end

		if (restart) begin
			s_d.wr_ptr = 11'h000;
			s_d.filled = 12'h000;
			s_d.have_prev = 1'b0;
			s_d.per_cnt = 13'h0000;
			s_d.start_ptr = 11'h000;
			s_d.post_left = NRM_TOTAL[(s_d.tb < NRM_ENTRIES) ? s_d.tb : 4'(NRM_ENTRIES - 1)];
			unique case (s_d.mode)
				MODE_FREE: s_d.fsm = ST_POST;
				MODE_ROLL: s_d.fsm = ST_ROLL;
				default: s_d.fsm = ST_ARMED;
			endcase
		end

		// Busy is kept in a flop so the output carries no decode logic.
		s_d.busy = (s_d.fsm inside {ST_ARMED, ST_POST, ST_ROLL});
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Only constants load under reset; control settles idle with safe masks.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.waitreq <= 1'b1;
			s_q.fsm <= ST_IDLE;
			s_q.mode <= MODE_SINGLE;
			s_q.couple <= CPL_DC;
			s_q.rising <= 1'b1;
			s_q.level <= RST_LEVEL;
			s_q.tmask <= RST_TMASK;
			s_q.dmask <= {NCH{RST_DMASK}};
		end else begin
			s_q <= s_d;
		end
	end

	// Sample memory has no reset; readback is meaningful only after a record.
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// Outputs straight from state flops.
	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	assign capture_busy = s_q.busy;
	assign record_ready = s_q.done;

endmodule : ftc_top

//--- sim/ftc_top_sva.sv
// Purpose: Protocol and capture checks on the trace capture ports.
// Assumes: Full-word writes to CHSRC when channels are set up.
// Notes: Channel enables are shadowed from completed writes.
`timescale 1ns/10ps
module ftc_top_sva import ftc_pkg::*; #(
	parameter int TICK_CYCLES = BASE_CYCLES,
	parameter int DEPTH = ROLL_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register bus
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Status and capture
	input wire ftc_status_t status_in,
	input wire logic capture_busy,
	input wire logic record_ready
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic wr_done;
	logic start_go;
	logic clr_go;
	logic ok_en;
	logic [3:0] en_q;
	// Completed writes, decoded the way the slave applies them.
	assign wr_done = avs_write && !avs_waitrequest;
	assign start_go = wr_done && avs_address == REG_CTRL && avs_byteenable[0] && avs_writedata[0];
	assign clr_go = wr_done && avs_address == REG_STATUS && avs_byteenable[0] && avs_writedata[2];
	assign ok_en = en_q inside {4'h1, 4'h3, 4'h7, 4'hf};
	// Shadow of the enables; a partial write is not tracked.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			en_q <= 4'h0;
		else if (wr_done && avs_address == REG_CHSRC && avs_byteenable[1:0] == 2'h3)
			en_q <= {avs_writedata[15], avs_writedata[11], avs_writedata[7], avs_writedata[3]};
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wait_one_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	idle_wait_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low without request");
	unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address > REG_RECINFO
		|=> avs_readdata == 32'h0) else $error("unmapped read not zero");
	refuse_start_a: assert property (start_go && !ok_en && !capture_busy |=> !capture_busy)
		else $error("start with gap in channels accepted");
	accept_start_a: assert property (start_go && ok_en && !avs_writedata[1] |=> capture_busy)
		else $error("valid start not accepted");
	idle_hold_a: assert property (!capture_busy && !start_go |=> !capture_busy)
		else $error("capture began without start");
	ready_hold_a: assert property (record_ready && !clr_go && !start_go |=> record_ready)
		else $error("record ready dropped");
	ready_cause_a: assert property ($rose(record_ready) |-> $past(capture_busy))
		else $error("record ready without capture");
	cover property (start_go && ok_en);
	cover property (start_go && !ok_en);
	cover property ($rose(record_ready));
endmodule : ftc_top_sva

//--- sim/ftc_host_model.sv
// Purpose: Host software model that reaches the capture registers.
// Assumes: Avalon-MM with waitrequest, one request at a time.
// Notes: Released lines show inverted values so stale data never passes.
`timescale 1ns/10ps
module ftc_host_model (
	// Clock
	input wire logic clk,
	// Avalon-MM master side
	output logic [5:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	// Idle bus at time zero.
	initial begin
		avs_address = 6'h3f;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end

	// One transfer, held until waitrequest is low at an edge; no fixed latency assumed.
	task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask : xfer
endmodule : ftc_host_model

//--- sim/ftc_top_tb.sv
// Purpose: Self-checking bench for the trace capture unit.
// Assumes: Short tick so records finish in a few hundred cycles.
// Notes: Flags are sampled on the falling edge to avoid races.
`timescale 1ns/10ps
module ftc_top_tb import ftc_pkg::*;;
	localparam int TICK = 2;
	logic clk;
	logic rst_b;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	ftc_status_t status_in;
	logic capture_busy;
	logic record_ready;
	logic [31:0] q;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	int n;

	ftc_top #(.TICK_CYCLES(TICK), .DEPTH(ROLL_DEPTH)) ftc_top_inst (.clk(clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.status_in(status_in), .capture_busy(capture_busy), .record_ready(record_ready));
	ftc_host_model host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// Clock and a ceiling well above the expected run length.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			final_report();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [5:0] a);
		host.xfer(1'b0, a, 32'h0, q);
	endtask : rd
	task automatic pins(input logic busy, input logic rdy);
		@(negedge clk);
		chk({30'h0, capture_busy, record_ready}, {30'h0, busy, rdy});
	endtask : pins
	task automatic wait_ready(input int e);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (record_ready !== 1'b1 && n < 3000);
		chk(32'(n >= e - TICK && n <= e + TICK + 8), 32'h1);
	endtask : wait_ready
	task automatic src(input int ch, input logic [15:0] v);
		@(posedge clk);
		status_in.word[ch] <= v;
	endtask : src
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(REG_CTRL);
		chk(q & 32'hfc, 32'h0);
		rd(REG_TMASK);
		chk(q & 32'hffff, {16'h0, RST_TMASK});
		rd(REG_DMASK01);
		chk(q, {RST_DMASK, RST_DMASK});
		wr(6'h30, 32'hffff_ffff);
		rd(6'h30);
		chk(q, 32'h0);
		pins(1'b0, 1'b0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_refuse;
		wr(REG_CHSRC, 32'h80);
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS);
		chk(q & 32'hb, 32'h8);
		pins(1'b0, 1'b0);
		wr(REG_STATUS, 32'h8);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_free;
		wr(REG_CHSRC, 32'h8);
		wr(REG_CTRL, 32'h9);
		wait_ready(40 * TICK);
		pins(1'b1, 1'b1);
		rd(REG_RECINFO);
		chk((q >> 16) & 32'hfff, 32'd40);
		wr(REG_CTRL, 32'h18);
		wr(REG_STATUS, 32'h4);
		wait_ready(80 * TICK - 6);
		rd(REG_RECINFO);
		chk((q >> 16) & 32'hfff, 32'd80);
		wr(REG_CTRL, 32'h2);
		wr(REG_STATUS, 32'h4);
		$display("test free done");
	endtask : t_free
	task automatic t_single_dig;
		logic [31:0] s;
		src(0, 16'h0024);
		wr(REG_CHSRC, 32'h1_0008);
		wr(REG_TRIG, 32'h14);
		wr(REG_LEVEL, 32'h7fff);
		wr(REG_TMASK, 32'h64);
		wr(REG_CTRL, 32'h1);
		repeat (200) @(negedge clk);
		pins(1'b1, 1'b0);
		src(0, 16'h0064);
		wait_ready(40 * TICK);
		repeat (100) @(negedge clk);
		pins(1'b0, 1'b1);
		rd(REG_RECINFO);
		s = q & 32'h7ff;
		wr(REG_RDADDR, s);
		rd(REG_RDDATA);
		chk(q & 32'hffff, 32'h64);
		wr(REG_DMASK01, 32'hffff_0007);
		wr(REG_RDADDR, s);
		rd(REG_RDDATA);
		chk(q, 32'h4);
		wr(REG_STATUS, 32'h4);
		pins(1'b0, 1'b0);
		$display("test digital trigger done");
	endtask : t_single_dig
	task automatic t_repeat_dc;
		src(1, 16'h0200);
		wr(REG_CHSRC, 32'h98);
		wr(REG_TRIG, 32'h1);
		wr(REG_LEVEL, 32'h0100);
		wr(REG_CTRL, 32'h5);
		repeat (100) @(negedge clk);
		pins(1'b1, 1'b0);
		src(1, 16'h0050);
		wait_ready(40 * TICK);
		pins(1'b1, 1'b1);
		wr(REG_CTRL, 32'h2);
		wr(REG_STATUS, 32'h4);
		$display("test repeat done");
	endtask : t_repeat_dc
	task automatic t_roll;
		wr(REG_CHSRC, 32'h8);
		wr(REG_CTRL, 32'hd);
		repeat (40 * 16 * TICK) @(negedge clk);
		rd(REG_STATUS);
		n = (q >> 16) & 32'h7ff;
		chk(32'(n >= 39 && n <= 41), 32'h1);
		rd(REG_RECINFO);
		chk((q >> 16) & 32'hfff, 32'd2000);
		pins(1'b1, 1'b0);
		wr(REG_CTRL, 32'h2);
		$display("test roll done");
	endtask : t_roll
	// A DC trigger would never see a rising edge here; only AC removes the offset.
	task automatic t_ac_pre;
		logic [31:0] s;
		src(0, 16'h0100);
		wr(REG_CHSRC, 32'h8);
		wr(REG_TRIG, 32'h000a_000c);
		wr(REG_LEVEL, 32'h0040);
		wr(REG_CTRL, 32'h1);
		repeat (200) @(negedge clk);
		pins(1'b1, 1'b0);
		src(0, 16'h0300);
		wait_ready(30 * TICK);
		pins(1'b0, 1'b1);
		rd(REG_RECINFO);
		s = q & 32'h7ff;
		wr(REG_RDADDR, (s + 9) % 40);
		rd(REG_RDDATA);
		chk(q, 32'h100);
		wr(REG_RDADDR, (s + 10) % 40);
		rd(REG_RDDATA);
		chk(q, 32'h300);
		wr(REG_STATUS, 32'h4);
		$display("test ac pretrigger done");
	endtask : t_ac_pre

	// Main sequence.
	initial begin
		rst_b = 1'b0;
		status_in = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_refuse();
		t_free();
		t_single_dig();
		t_repeat_dc();
		t_roll();
		t_ac_pre();
		final_report();
	end
endmodule : ftc_top_tb

bind ftc_top ftc_top_sva #(.TICK_CYCLES(TICK_CYCLES), .DEPTH(DEPTH)) ftc_top_sva_inst (
	.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .status_in(status_in),
	.capture_busy(capture_busy), .record_ready(record_ready));
